/* File: hw/vdsf_unit.sv */
// vector datapath: dot-product subtract, float add, quiet compares, class mask
// assumes the issue logic holds operands for the issue cycle and reads the
// result one cycle later; registers sit on a plain strobe port
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Function
// - signed dot-sub: element minus sum of sign-extended half-width products
// - unsigned dot-sub zero-extends half-width subelements before multiplying
// - subtract summed products from destination, keep low bits, wrap
// - dot sources are half-width integers; destination widths 16, 32, 64
// - dot-sub never raises value-dependent exceptions
// - float add of matching elements, 32 and 64 bit, IEEE rules
// - add and compares raise IEEE exceptions as prescribed
// - always-false clears elements, yet signaling NaN raises invalid
// - equal gives all ones when ordered and equal, else zeros
// - less-or-equal gives all ones when ordered and first not greater
// - compares never signal inexact when subnormals are flushed
// - on a compare exception the element result is all zeros
// - class writes a 10-bit mask for every source element
// - mask bits 0..5: sNaN, qNaN, negative inf, normal, subnormal, zero
// - mask bits 6..9: positive inf, normal, subnormal, zero
// - class element bits above the mask are zero
// - class ignores flush-to-zero and raises no exceptions
// - raise reserved-instruction, unit-disabled and float exceptions to core
module vdsf_unit import vdsf_pkg::*; #(
	parameter int VW = VDSF_VREG_W
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic issue_valid,
	input wire vdsf_op_t issue_op,
	input wire vdsf_fmt_t element_format,
	input wire logic [VW-1:0] dest_vector,
	input wire logic [VW-1:0] first_src_vector,
	input wire logic [VW-1:0] second_src_vector,
	output logic res_valid,
	output logic [VW-1:0] res_vector,
	output vdsf_flags_t res_flags,
	output logic exc_reserved,
	output logic exc_disabled,
	output logic exc_fp,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);
	if (VW < 64 || VW % 64 != 0)
		$error("vector width must be a positive multiple of 64");

	logic [6:0] vector_control_status_reg;
	logic [4:0] status;
	logic [4:0] mask;
	wire unit_en = vector_control_status_reg[VDSF_CTRL_EN_BIT];
	wire flush_to_zero_bit = vector_control_status_reg[VDSF_CTRL_FTZ_BIT];
	wire [4:0] trap_en = vector_control_status_reg[VDSF_CTRL_TRAP_LSB +: VDSF_FLAGS_W];

	// dot-product subtract, one result vector per signedness and width
	wire [VW-1:0] dot_res [2][3];
	for (genvar u = 0; u < 2; u++) begin : g_sg
		for (genvar w = 0; w < 3; w++) begin : g_w
			localparam int EW = 16 << w;
			localparam int HW = EW / 2;
			for (genvar i = 0; i < VW / EW; i++) begin : g_el
				wire [EW-1:0] xs = first_src_vector[i*EW +: EW];
				wire [EW-1:0] xt = second_src_vector[i*EW +: EW];
				// extension bit: sign for signed, zero for unsigned
				wire signed [HW:0] a1 = {(u == 0) & xs[EW-1], xs[EW-1:HW]};
				wire signed [HW:0] b1 = {(u == 0) & xt[EW-1], xt[EW-1:HW]};
				wire signed [HW:0] a0 = {(u == 0) & xs[HW-1], xs[HW-1:0]};
				wire signed [HW:0] b0 = {(u == 0) & xt[HW-1], xt[HW-1:0]};
				wire signed [EW+1:0] p1 = a1 * b1;
				wire signed [EW+1:0] p0 = a0 * b0;
				// modular arithmetic: no saturation, no carry out
				assign dot_res[u][w][i*EW +: EW] =
					dest_vector[i*EW +: EW] - p1[EW-1:0] - p0[EW-1:0];
			end
		end
	end

	// floating-point lanes, index 0 single, 1 double
	wire [VW-1:0] add_res [2];
	wire [VW-1:0] eq_res [2];
	wire [VW-1:0] le_res [2];
	wire [VW-1:0] cls_res [2];
	wire vdsf_flags_t add_or [2];
	wire inv_or [2];
	for (genvar s = 0; s < 2; s++) begin : g_fp
		localparam int EW = 32 << s;
		localparam int EXP = (s == 0) ? 8 : 11;
		localparam int N = VW / EW;
		wire vdsf_flags_t acc [N+1];
		wire [N-1:0] inv_v;
		assign acc[0] = '0;
		for (genvar i = 0; i < N; i++) begin : g_el
			wire [EW-1:0] sum;
			vdsf_flags_t fl;
			logic eq, le, inv;
			logic [VDSF_CLASS_W-1:0] cls;
			vdsf_fp_elem #(
				.EW(EW),
				.EXP(EXP),
				.MAN(EW - 1 - EXP)
			) u_elem (
				.a(first_src_vector[i*EW +: EW]),
				.b(second_src_vector[i*EW +: EW]),
				.ftz(flush_to_zero_bit),
				.sum(sum),
				.add_fl(fl),
				.eq(eq),
				.le(le),
				.cmp_inv(inv),
				.cls(cls)
			);
			assign add_res[s][i*EW +: EW] = sum;
			assign eq_res[s][i*EW +: EW] = {EW{eq & !inv}};
			assign le_res[s][i*EW +: EW] = {EW{le & !inv}};
			assign cls_res[s][i*EW +: EW] = {{(EW-VDSF_CLASS_W){1'b0}}, cls};
			assign acc[i+1] = acc[i] | fl;
			assign inv_v[i] = inv;
		end
		assign add_or[s] = acc[N];
		assign inv_or[s] = |inv_v;
	end

	logic [VW-1:0] next_res;
	vdsf_flags_t next_flags;
	logic bad;
	logic dbl;
	always_comb begin
		next_res = '0;
		next_flags = '0;
		bad = 1'b0;
		dbl = element_format == FMT_DOUBLE;
		case (issue_op)
			signed_dot_sub_op, unsigned_dot_sub_op: begin
				bad = element_format == FMT_BYTE;
				if (!bad)
					next_res = dot_res[issue_op == unsigned_dot_sub_op][element_format - 2'd1];
				// flags stay clear for integer work
				next_flags = '0;
			end
			float_add_op: begin
				next_res = add_res[dbl];
				next_flags = add_or[dbl];
			end
			float_cmp_false_op: begin
				next_flags.invalid = inv_or[dbl];
			end
			float_cmp_equal_op: begin
				next_res = eq_res[dbl];
				next_flags.invalid = inv_or[dbl];
			end
			float_cmp_less_equal_op: begin
				next_res = le_res[dbl];
				next_flags.invalid = inv_or[dbl];
			end
			float_class_op: begin
				next_res = cls_res[dbl];
			end
			default: bad = 1'b1;
		endcase
		if (issue_op != signed_dot_sub_op && issue_op != unsigned_dot_sub_op &&
			!(element_format == FMT_WORD || dbl))
			bad = 1'b1;
	end

	wire accept = issue_valid && unit_en && !bad;
	wire [4:0] set_bits = accept ? next_flags : 5'h00;
	vdsf_op_t res_op;
	vdsf_fmt_t res_fmt;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			res_valid <= 1'b0;
			res_vector <= '0;
			res_flags <= '0;
			res_op <= signed_dot_sub_op;
			res_fmt <= FMT_BYTE;
		end else begin
			res_valid <= accept;
			if (accept) begin
				res_vector <= next_res;
				res_flags <= next_flags;
				res_op <= issue_op;
				res_fmt <= element_format;
			end
		end
	end

	// disabled unit is reported ahead of a bad encoding
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			exc_disabled <= 1'b0;
			exc_reserved <= 1'b0;
			exc_fp <= 1'b0;
		end else begin
			exc_disabled <= issue_valid && !unit_en;
			exc_reserved <= issue_valid && unit_en && bad;
			exc_fp <= accept && |(next_flags & trap_en);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			vector_control_status_reg <= VDSF_CTRL_RST;
			mask <= VDSF_MASK_RST;
		end else if (reg_wr) begin
			if (reg_addr == VDSF_CTRL_OFS)
				vector_control_status_reg <= reg_wdata[6:0];
			if (reg_addr == VDSF_MASK_OFS)
				mask <= reg_wdata[4:0];
		end
	end

	// a flag raised in the clearing cycle survives the clear
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			status <= VDSF_STATUS_RST;
		else if (reg_wr && reg_addr == VDSF_STATUS_OFS)
			status <= (status & ~reg_wdata[4:0]) | set_bits;
		else
			status <= status | set_bits;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				VDSF_CTRL_OFS: reg_rdata <= {25'h000_0000, vector_control_status_reg};
				VDSF_STATUS_OFS: reg_rdata <= {27'h000_0000, status};
				VDSF_MASK_OFS: reg_rdata <= {27'h000_0000, mask};
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	assign irq = |(status & mask);

	// low mask bits of every element of the format; the rest of a class result is zero
	function automatic logic [VW-1:0] cls_keep(input vdsf_fmt_t f);
		logic [VW-1:0] m;
		m = '0;
		for (int i = 0; i < VW / 32; i++) begin
			if (f != FMT_DOUBLE || i % 2 == 0)
				m[i*32 +: VDSF_CLASS_W] = '1;
		end
		return m;
	endfunction : cls_keep

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence seq_issue_ok;
		issue_valid && unit_en && !bad;
	endsequence
	sequence seq_issue_off;
		issue_valid && !unit_en;
	endsequence
	sequence seq_dot_byte;
		issue_valid && unit_en && element_format == FMT_BYTE &&
			(issue_op == signed_dot_sub_op || issue_op == unsigned_dot_sub_op);
	endsequence

	AST_RES_ONE_CYCLE: assert property (seq_issue_ok |-> ##1 res_valid && !exc_reserved)
		else $error("accepted operation gave no result one cycle later");
	AST_DISABLED: assert property (seq_issue_off |=> exc_disabled && !res_valid)
		else $error("disabled unit did not raise the disabled exception");
	AST_RESERVED: assert property (seq_dot_byte |=> exc_reserved && !res_valid)
		else $error("byte dot-sub format not refused");
	AST_DOT_NO_FLAGS: assert property (res_valid &&
		(res_op == signed_dot_sub_op || res_op == unsigned_dot_sub_op)
		|-> res_flags == '0 && !exc_fp)
		else $error("dot-sub raised a floating-point flag");
	AST_FALSE_ZERO: assert property (res_valid && res_op == float_cmp_false_op
		|-> res_vector == '0)
		else $error("always-false compare left bits set");
	AST_CLASS_UPPER: assert property (res_valid && res_op == float_class_op
		|-> res_flags == '0 && (res_vector & ~cls_keep(res_fmt)) == '0)
		else $error("class result has bits above the mask");
	AST_CMP_NO_INEXACT: assert property (res_valid && (res_op == float_cmp_equal_op ||
		res_op == float_cmp_less_equal_op) |-> !res_flags.inexact)
		else $error("compare signalled inexact");
	AST_FALSE_QUIET: assert property (res_valid && res_op == float_cmp_false_op
		|-> !res_flags.inexact && !res_flags.overflow && !res_flags.underflow)
		else $error("always-false compare raised a flag other than invalid");
	AST_STICKY_IRQ: assert property (res_valid && |(res_flags & mask)
		|-> irq ##1 (irq || $past(reg_wr)))
		else $error("unmasked flag did not raise the interrupt");
	AST_SET_WINS: assert property (|set_bits
		|=> (status & $past(set_bits)) == $past(set_bits))
		else $error("raised flag missing from status");
	AST_ONE_ANSWER: assert property (issue_valid
		|=> $onehot({res_valid, exc_reserved, exc_disabled}))
		else $error("request did not get exactly one answer");
	AST_FP_WITH_RESULT: assert property (exc_fp |-> res_valid)
		else $error("floating-point exception without a result");
	AST_DOT_VALUE: assert property (issue_valid && unit_en &&
		issue_op == signed_dot_sub_op && element_format == FMT_HALF
		|=> res_vector[15:0] == $past(dot_res[0][0][15:0]))
		else $error("dot-sub result not captured");
endmodule : vdsf_unit

/* File: include/vdsf_pkg.sv */
// package for the vector dot-subtract / float add, compare and class datapath
// assumes one core clock domain and a plain register port on the core side
package vdsf_pkg;
	typedef enum logic [2:0] {
		signed_dot_sub_op,
		unsigned_dot_sub_op,
		float_add_op,
		float_cmp_false_op,
		float_cmp_equal_op,
		float_cmp_less_equal_op,
		float_class_op
	} vdsf_op_t;

	// element width selector: byte, half, word, double
	typedef enum logic [1:0] {FMT_BYTE, FMT_HALF, FMT_WORD, FMT_DOUBLE} vdsf_fmt_t;

	typedef struct packed {
		logic invalid;
		logic div_zero;
		logic overflow;
		logic underflow;
		logic inexact;
	} vdsf_flags_t;

	localparam int VDSF_VREG_W = 128;
	localparam int VDSF_FLAGS_W = 5;
	localparam int VDSF_CLASS_W = 10;
	localparam int VDSF_RES_LAT = 1;

	localparam logic [3:0] VDSF_CTRL_OFS = 4'h0;
	localparam logic [3:0] VDSF_STATUS_OFS = 4'h4;
	localparam logic [3:0] VDSF_MASK_OFS = 4'h8;

	localparam int VDSF_CTRL_EN_BIT = 0;
	localparam int VDSF_CTRL_FTZ_BIT = 1;
	localparam int VDSF_CTRL_TRAP_LSB = 2;
	localparam logic [6:0] VDSF_CTRL_RST = 7'h01;
	localparam logic [4:0] VDSF_STATUS_RST = 5'h00;
	localparam logic [4:0] VDSF_MASK_RST = 5'h00;
endpackage : vdsf_pkg

/* File: hw/vdsf_fp_elem.sv */
// one floating-point element: add, quiet compares and class mask
// assumes operands are stable for the whole cycle; purely combinational
`timescale 1ns/1ps
module vdsf_fp_elem import vdsf_pkg::*; #(
	parameter int EW = 32,
	parameter int EXP = 8,
	parameter int MAN = 23
) (
	input wire logic [EW-1:0] a,
	input wire logic [EW-1:0] b,
	input wire logic ftz,
	output logic [EW-1:0] sum,
	output vdsf_flags_t add_fl,
	output logic eq,
	output logic le,
	output logic cmp_inv,
	output logic [VDSF_CLASS_W-1:0] cls
);
	localparam int W = MAN + 4;
	localparam logic [EXP-1:0] EMAX = '1;
	localparam logic [EW-1:0] QNAN = {1'b0, EMAX, 1'b1, {(MAN-1){1'b0}}};

	logic sa, sb;
	logic [EXP-1:0] ea, eb;
	logic [MAN-1:0] fa, fb;
	assign {sa, ea, fa} = a;
	assign {sb, eb, fb} = b;

	wire nan_a = (ea == EMAX) && (fa != '0);
	wire nan_b = (eb == EMAX) && (fb != '0);
	wire snan_a = nan_a && !fa[MAN-1];
	wire snan_b = nan_b && !fb[MAN-1];
	wire inf_a = (ea == EMAX) && (fa == '0);
	wire inf_b = (eb == EMAX) && (fb == '0);
	wire sub_a = (ea == '0) && (fa != '0);
	wire sub_b = (eb == '0) && (fb != '0);
	wire zr_a = (ea == '0) && (fa == '0);
	wire zr_b = (eb == '0) && (fb == '0);
	wire nrm_a = !zr_a && !sub_a && (ea != EMAX);
	// flushed view, used by add and compares only
	wire fz_a = zr_a || (ftz && sub_a);
	wire fz_b = zr_b || (ftz && sub_b);
	wire [EW-2:0] mag_a = fz_a ? '0 : {ea, fa};
	wire [EW-2:0] mag_b = fz_b ? '0 : {eb, fb};

	// raw encoding, flush control deliberately not applied
	assign cls = {zr_a & !sa, sub_a & !sa, nrm_a & !sa, inf_a & !sa,
		zr_a & sa, sub_a & sa, nrm_a & sa, inf_a & sa,
		nan_a & !snan_a, snan_a};

	// quiet compares: only a signaling NaN raises invalid, never inexact
	wire unord = nan_a || nan_b;
	wire both_z = fz_a && fz_b;
	assign cmp_inv = snan_a || snan_b;
	assign eq = !unord && (both_z || (sa == sb && mag_a == mag_b));
	wire lt = !unord && !both_z &&
		((sa != sb) ? sa : (sa ? (mag_a > mag_b) : (mag_a < mag_b)));
	assign le = eq || lt;

	logic big, sl, ss;
	logic [EW-2:0] ml, ms;
	logic [W-1:0] wa, wb, wsh;
	logic [W:0] s, n;
	logic [MAN+1:0] mr;
	logic g, r, st, rup, inx, tiny, ovf;
	int xa, xs, d, lz, sh, e, ef;

	always_comb begin
		big = mag_a >= mag_b;
		sl = big ? sa : sb;
		ss = big ? sb : sa;
		ml = big ? mag_a : mag_b;
		ms = big ? mag_b : mag_a;
		xa = (ml[EW-2:MAN] == '0) ? 1 : int'(ml[EW-2:MAN]);
		xs = (ms[EW-2:MAN] == '0) ? 1 : int'(ms[EW-2:MAN]);
		wa = {ml[EW-2:MAN] != '0, ml[MAN-1:0], 3'b000};
		wb = {ms[EW-2:MAN] != '0, ms[MAN-1:0], 3'b000};
		d = xa - xs;
		// bits shifted out fold into the sticky position
		if (d >= W)
			wsh = {{(W-1){1'b0}}, |wb};
		else
			wsh = (wb >> d) | W'(|(wb & ~({W{1'b1}} << d)));
		s = (sl == ss) ? {1'b0, wa} + {1'b0, wsh} : {1'b0, wa} - {1'b0, wsh};
		lz = W;
		for (int k = 0; k < W; k++) begin
			if (s[k])
				lz = W - 1 - k;
		end
		if (s[W]) begin
			n = {1'b0, s[W:1]} | (W+1)'(s[0]);
			e = xa + 1;
			sh = 0;
		end else begin
			sh = (lz < xa - 1) ? lz : xa - 1;
			n = s << sh;
			e = xa - sh;
		end
		g = n[2];
		r = n[1];
		st = n[0];
		inx = g | r | st;
		rup = g & (r | st | n[3]);
		mr = {1'b0, n[W-1:3]} + (MAN+2)'(rup);
		ef = mr[MAN+1] ? e + 1 : (mr[MAN] ? e : 0);
		ovf = ef >= int'(EMAX);
		tiny = (ef == 0) && ((mr != '0) || inx);
		add_fl = '0;
		// IEEE 754-2008 add, round to nearest even
		if (unord) begin
			sum = QNAN;
			add_fl.invalid = snan_a || snan_b;
		end else if (inf_a && inf_b && sa != sb) begin
			sum = QNAN;
			add_fl.invalid = 1'b1;
		end else if (inf_a) begin
			sum = a;
		end else if (inf_b) begin
			sum = b;
		end else if (both_z) begin
			sum = {sa & sb, {(EW-1){1'b0}}};
		end else if (s == '0) begin
			sum = '0;
		end else if (ovf) begin
			sum = {sl, EMAX, {MAN{1'b0}}};
			add_fl.overflow = 1'b1;
			add_fl.inexact = 1'b1;
		end else if (tiny && ftz) begin
			sum = {sl, {(EW-1){1'b0}}};
			add_fl.underflow = 1'b1;
			add_fl.inexact = 1'b1;
		end else begin
			sum = {sl, EXP'(ef), mr[MAN+1] ? {MAN{1'b0}} : mr[MAN-1:0]};
			add_fl.inexact = inx;
			add_fl.underflow = tiny && inx;
		end
	end
endmodule : vdsf_fp_elem

/* File: sim/vdsf_core_model.sv */
// core issue model: one request per go pulse, then collects the answer
// assumes the unit answers within a few cycles on the same clock
`timescale 1ns/1ps
module vdsf_core_model import vdsf_pkg::*; (
	input wire logic clk_sys,
	input wire logic go,
	input wire logic [2:0] go_op,
	input wire vdsf_fmt_t go_fmt,
	input wire logic [383:0] go_data,
	output logic issue_valid,
	output vdsf_op_t issue_op,
	output vdsf_fmt_t element_format,
	output logic [383:0] ops,
	input wire logic res_valid,
	input wire logic exc_reserved,
	input wire logic exc_disabled,
	input wire logic exc_fp,
	output logic done,
	output logic [3:0] kind
);
	initial begin
		issue_valid = 1'b0;
		ops = '0;
		done = 1'b0;
		kind = 4'h0;
	end
	// idle operand lines toggle so a stale value never passes for a request
	always @(posedge clk_sys) begin
		issue_valid <= go;
		issue_op <= vdsf_op_t'(go_op);
		element_format <= go_fmt;
		ops <= go ? go_data : ~ops;
		done <= res_valid | exc_reserved | exc_disabled;
		if (res_valid | exc_reserved | exc_disabled) begin
			kind <= {exc_fp, exc_disabled, exc_reserved, res_valid};
		end
	end
endmodule : vdsf_core_model

/* File: sim/vdsf_unit_test.sv */
// self-checking bench for the vector dot-sub / float unit
// assumes one 50 MHz clock and the core model in front of the issue port
`timescale 1ns/1ps
module vdsf_unit_test import vdsf_pkg::*; ;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic go = 1'b0;
	logic [2:0] go_op = 3'h0;
	vdsf_fmt_t go_fmt = FMT_WORD;
	logic [383:0] go_data = '0;
	logic issue_valid, done, res_valid, exc_reserved, exc_disabled, exc_fp, irq;
	vdsf_op_t issue_op;
	vdsf_fmt_t element_format;
	logic [383:0] ops;
	logic [127:0] res_vector, d, a, b;
	vdsf_flags_t res_flags;
	logic [3:0] kind;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] rnd = 32'h0000_d4f9;
	logic [31:0] reg_rdata;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;
	logic [31:0] cls_in [10] = '{32'h7fa0_0000, 32'h7fc0_0000, 32'hff80_0000, 32'hbf80_0000,
		32'h8000_0001, 32'h8000_0000, 32'h7f80_0000, 32'h3f80_0000, 32'h0000_0001, 32'h0};
	localparam logic [127:0] ONE = {4{32'h3f80_0000}};

	vdsf_core_model u_vdsf_core_model (.clk_sys(clk_sys), .go(go), .go_op(go_op),
		.go_fmt(go_fmt), .go_data(go_data), .issue_valid(issue_valid), .issue_op(issue_op),
		.element_format(element_format), .ops(ops), .res_valid(res_valid),
		.exc_reserved(exc_reserved), .exc_disabled(exc_disabled), .exc_fp(exc_fp),
		.done(done), .kind(kind));
	vdsf_unit #(.VW(128)) u_vdsf_unit (.clk_sys(clk_sys), .rstn(rstn),
		.issue_valid(issue_valid), .issue_op(issue_op), .element_format(element_format),
		.dest_vector(ops[383:256]), .first_src_vector(ops[255:128]),
		.second_src_vector(ops[127:0]), .res_valid(res_valid), .res_vector(res_vector),
		.res_flags(res_flags), .exc_reserved(exc_reserved), .exc_disabled(exc_disabled),
		.exc_fp(exc_fp), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

	always #10 clk_sys = ~clk_sys;

	// the whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [127:0] rand128();
		logic [127:0] v;
		for (int i = 0; i < 128; i++) begin
			rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
			v[i] = rnd[0];
		end
		return v;
	endfunction : rand128

	function automatic logic [63:0] ext(input logic [63:0] v, input int h, input logic s);
		return (s && v[h-1]) ? (v | ~((64'h1 << h) - 64'h1)) : v;
	endfunction : ext

	function automatic logic [127:0] dsub(input logic s, input int ew,
		input logic [127:0] dd, input logic [127:0] aa, input logic [127:0] bb);
		logic [127:0] r;
		logic [63:0] m, t;
		int h;
		r = '0;
		h = ew / 2;
		m = (64'h1 << h) - 64'h1;
		for (int i = 0; i < 128 / ew; i++) begin
			t = 64'(dd >> (i * ew)) - ext(64'(aa >> (i * ew + h)) & m, h, s)
				* ext(64'(bb >> (i * ew + h)) & m, h, s)
				- ext(64'(aa >> (i * ew)) & m, h, s) * ext(64'(bb >> (i * ew)) & m, h, s);
			if (ew < 64) begin
				t = t & ((64'h1 << ew) - 64'h1);
			end
			r = r | (128'(t) << (i * ew));
		end
		return r;
	endfunction : dsub

	task automatic reg_write(input logic [3:0] ad, input logic [31:0] wd);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= wd;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_check(input logic [3:0] ad, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(128'(reg_rdata), 128'(exp));
	endtask : reg_check

	// one request through the core model; vector and flags only when a result comes
	task automatic run(input logic [2:0] op, input vdsf_fmt_t f, input logic [127:0] dd,
		input logic [127:0] aa, input logic [127:0] bb, input logic [3:0] k,
		input logic [127:0] ev, input logic [4:0] ef);
		int n;
		@(posedge clk_sys);
		go <= 1'b1;
		go_op <= op;
		go_fmt <= f;
		go_data <= {dd, aa, bb};
		@(posedge clk_sys);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (done !== 1'b1 && n < 8);
		chk(128'({done, kind}), 128'({1'b1, k}));
		if (k[0]) begin
			chk(res_vector, ev);
			chk(128'(res_flags), 128'(ef));
		end
	endtask : run

	initial begin
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		#1;
		chk(128'({res_valid, exc_reserved, exc_disabled, exc_fp, irq}), 128'h0);
		reg_check(VDSF_CTRL_OFS, 32'h01);
		reg_check(VDSF_MASK_OFS, 32'h00);
		reg_check(4'hc, 32'h00);
		$display("test reset done");
		for (int o = 0; o < 2; o++) begin
			for (int f = 1; f < 4; f++) begin
				for (int k = 0; k < 5; k++) begin
					d = rand128();
					a = rand128();
					b = rand128();
					if (k == 0) begin
						a = '1;
						b = {8{16'h8000}};
					end
					run(3'(o), vdsf_fmt_t'(f), d, a, b, 4'h1, dsub(o == 0, 8 << f, d, a, b), 5'h0);
				end
			end
		end
		reg_check(VDSF_STATUS_OFS, 32'h00);
		$display("test dot-sub done");
		run(3'(signed_dot_sub_op), FMT_BYTE, d, a, b, 4'h2, '0, 5'h0);
		run(3'h7, FMT_WORD, d, a, b, 4'h2, '0, 5'h0);
		run(3'(float_add_op), FMT_HALF, d, a, b, 4'h2, '0, 5'h0);
		run(3'(float_add_op), FMT_WORD, d, ONE, {4{32'h4000_0000}}, 4'h1, {4{32'h4040_0000}}, 5'h0);
		run(3'(float_add_op), FMT_DOUBLE, d, {2{64'h3ff0_0000_0000_0000}},
			{2{64'h3ff0_0000_0000_0000}}, 4'h1, {2{64'h4000_0000_0000_0000}}, 5'h0);
		run(3'(float_add_op), FMT_WORD, d, ONE, {4{32'h3080_0000}}, 4'h1, ONE, 5'h01);
		$display("test add done");
		for (int z = 0; z < 2; z++) begin
			reg_write(VDSF_CTRL_OFS, 32'(z * 2 + 1));
			for (int k = 0; k < 10; k++) begin
				run(3'(float_class_op), FMT_WORD, d, {4{cls_in[k]}}, b, 4'h1, {4{22'h0, 10'(1 << k)}}, 5'h0);
			end
			run(3'(float_cmp_equal_op), FMT_WORD, d, {4{32'h0000_0001}}, '0, 4'h1, {128{z == 1}}, 5'h0);
		end
		run(3'(float_class_op), FMT_DOUBLE, d, {2{64'h8000_0000_0000_0001}}, b, 4'h1, {2{54'h0, 10'h010}}, 5'h0);
		reg_write(VDSF_CTRL_OFS, 32'h01);
		$display("test class done");
		a = {32'h3f80_0000, 32'h4000_0000, 32'hbf80_0000, 32'h7fc0_0000};
		run(3'(float_cmp_equal_op), FMT_WORD, d, a, ONE, 4'h1, {32'hffff_ffff, 64'h0, 32'h0}, 5'h0);
		run(3'(float_cmp_less_equal_op), FMT_WORD, d, a, ONE, 4'h1, {32'hffff_ffff, 32'h0, 32'hffff_ffff, 32'h0}, 5'h0);
		b = {96'(ONE), 32'h7fa0_0000};
		run(3'(float_cmp_false_op), FMT_WORD, d, ONE, b, 4'h1, '0, 5'h10);
		run(3'(float_cmp_equal_op), FMT_WORD, d, ONE, b, 4'h1, {96'h0, 32'h0} | {{96{1'b1}}, 32'h0}, 5'h10);
		$display("test compare done");
		reg_check(VDSF_STATUS_OFS, 32'h11);
		chk(128'(irq), 128'h0);
		reg_write(VDSF_MASK_OFS, 32'h10);
		#1;
		chk(128'(irq), 128'h1);
		reg_write(VDSF_STATUS_OFS, 32'h10);
		#1;
		chk(128'(irq), 128'h0);
		reg_check(VDSF_STATUS_OFS, 32'h01);
		reg_write(VDSF_CTRL_OFS, 32'h41);
		run(3'(float_cmp_false_op), FMT_WORD, d, ONE, b, 4'h9, '0, 5'h10);
		run(3'(float_add_op), FMT_WORD, d, {4{32'h7f7f_ffff}}, {4{32'h7f7f_ffff}}, 4'h1,
			{4{32'h7f80_0000}}, 5'h05);
		run(3'(float_cmp_less_equal_op), FMT_DOUBLE, d, {64'hbff0_0000_0000_0000,
			64'h4000_0000_0000_0000}, {2{64'h3ff0_0000_0000_0000}}, 4'h1,
			{64'hffff_ffff_ffff_ffff, 64'h0}, 5'h0);
		reg_write(VDSF_CTRL_OFS, 32'h00);
		run(3'(float_add_op), FMT_WORD, d, ONE, ONE, 4'h4, '0, 5'h0);
		$display("test registers done");
		final_report();
	end
endmodule : vdsf_unit_test
